//--- tb_top.sv
// Self-checking bench of the status and error register bank.
// Assumes the bank answers and updates one cycle after each cause.
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] MID = 8'h5a;  // Arbitrary model code.
   localparam logic [7:0] RV  = 8'h01;  // Arbitrary firmware code.
   localparam logic [31:0] BITS [10] = '{32'h08000000, 32'h01000000, 32'h00040000,
      32'h00020000, 32'h00000800, 32'h00000400, 32'h8, 32'h4, 32'h2, 32'h1};
   localparam int QOFS [4] = '{0, 16, 24, 8};  // Byte place of error, fail, protection, setting.
   logic mclk_i, arst_n_i, tst, prt, hr, on, ren;       // Clock, reset and levels.
   logic [15:0] mc, sc, mp, sl, su, sv;                // Analogue values.
   logic [9:0]  src;                                   // Set sources in table order.
   logic [7:0]  dsi, prot, fail, setr, err, esr, stb;  // Status in and out.
   logic        bss, dsc, frs, ibc;                    // Summary and strobes.
   logic [31:0] exp;                                   // Expected condition registers.
   tsr_pkg::tsr_resp_t resp;                           // Answer from the bank.
   tsr_pkg::tsr_cmd_t  cmd;                            // Message to the bank.
   int fails, checks_done;                             // Mismatch and compare counts.
   tsr_host_model host (.mclk_i(mclk_i), .resp_i(resp), .cmd_o(cmd));
   tsr_status_bank #(.SEC_CYCLES(10), .MODEL_ID(MID), .ROM_VER(RV)) uut (
      .mclk_i(mclk_i), .arst_n_i(arst_n_i), .cmd_i(cmd), .resp_o(resp), .testing_i(tst),
      .protect_i(prt), .high_rated_i(hr), .output_on_i(on), .meas_current_i(mc),
      .set_current_i(sc), .meas_power_i(mp), .remote_enable_input_i(ren),
      .voltage_limit_i(src[0]), .overtemperature_i(src[1]), .upper_fail_i(src[2]),
      .lower_fail_i(src[3]), .resistance_range_setting_i(src[4]),
      .power_limit_setting_i(src[5]), .set_lower_i(sl), .set_upper_i(su),
      .set_voltage_i(sv), .invalid_msg_i(src[6]), .range_err_i(src[7]),
      .data_err_i(src[8]), .syntax_err_i(src[9]), .dev_status_i(dsi),
      .protection_cause_o(prot), .judgement_fail_o(fail), .bad_setting_cause_o(setr),
      .message_error_o(err), .event_status_o(esr), .status_byte_o(stb),
      .bad_setting_summary_o(bss), .dev_status_clear_o(dsc), .factory_reset_o(frs),
      .input_buffer_clear_o(ibc));
   // Compare one value and report a mismatch at once.
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] want);
      checks_done++;
      if (seen !== want) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
      end
   endtask : chk
   // Wait for the next falling edge, where inputs change and outputs are settled.
   task automatic step;
      @(negedge mclk_i);
   endtask : step
   // Print the counts and the verdict, then end the run.
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test
   // Free-running 200 MHz clock.
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   // Cut a hang short well after the tests should be over.
   initial begin
      #200000;
      fails++;
      finish_test();
   end
   // Main sequence of the tests.
   initial begin
      fails = 0; checks_done = 0; arst_n_i = 1'b0; tst = 0; prt = 0; hr = 0; on = 0;
      ren = 0; mc = '0; sc = '0; mp = '0; sl = '0; su = '0; sv = '0; src = '0; dsi = '0;
      exp = '0;
      repeat (6) step();
      arst_n_i = 1'b1;
      chk("regs", {prot, fail, setr, err}, 32'h0);
      // Each source pulses once; every bit must stay after the source is gone.
      for (int i = 0; i < 10; i++) begin
         src = 10'h1 << i;
         step();
         src = '0;
         step();
         exp |= BITS[i];
         chk("src", {prot, fail, setr, err}, exp);
      end
      chk("esr", esr, 32'h20);
      sc = 16'h0064; mc = 16'h006e; on = 1; mp = 16'h0096; sl = 16'h0005; su = 16'h0005;
      sv = 16'h021c;
      step();
      chk("edge", {prot, fail, setr, err}, exp);
      mc = 16'h006f; ren = 1; mp = 16'h0097; sl = 16'h0006; sv = 16'h021d;
      step();
      exp |= 32'h34000300;
      chk("over", {prot, fail, setr, err}, exp);
      chk("summary", bss, 1'b1);
      for (int q = 8; q < 12; q++) begin
         host.send(tsr_pkg::tsr_cmd_e_t'(q), 8'h00);
         chk("query", {host.got_q, host.last_q[7:0]}, {1'b1, exp[QOFS[q-8] +: 8]});
      end
      host.send(tsr_pkg::TSR_ESR_Q, 8'h00);
      chk("esr_q", {host.got_q, host.last_q}, 17'h10020);
      chk("esr_clr", esr, 32'h0);
      tst = 1;
      host.send(tsr_pkg::TSR_SRE, 8'h12);
      chk("refused", {host.got_q, esr}, 9'h010);
      host.send(tsr_pkg::TSR_SRE_Q, 8'h00);
      chk("sre_test", {host.got_q, host.last_q}, 17'h10000);
      tst = 0; prt = 1;
      host.send(tsr_pkg::TSR_SRE, 8'hff);
      chk("refused2", esr, 32'h10);
      host.send(tsr_pkg::TSR_STB_Q, 8'h00);
      chk("stb_prot", {host.got_q, host.last_q}, 17'h10030);
      prt = 0;
      host.send(tsr_pkg::TSR_SRE, 8'hff);
      host.send(tsr_pkg::TSR_SRE_Q, 8'h00);
      chk("sre_max", host.last_q, 32'hff);
      chk("mss", stb, 32'h70);
      prt = 1;
      host.send(tsr_pkg::TSR_IDN_Q, 8'h00);
      chk("idn", {host.got_q, host.last_q}, {1'b1, MID, RV});
      host.send(tsr_pkg::TSR_RST, 8'h00);
      chk("rst", {frs, prot, fail, setr, err}, {1'b1, exp});
      host.send(tsr_pkg::TSR_CLR, 8'h00);
      chk("clr", ibc, 1'b1);
      tst = 1; ren = 0; mp = '0; sl = '0; sv = '0; mc = sc;
      host.send(tsr_pkg::TSR_CLS, 8'h00);
      chk("cls", {dsc, prot, fail, setr, err, esr}, 41'h100_0000_0000);
      tst = 0; prt = 0; hr = 1; mp = 16'h00dc;
      step();
      chk("va220", prot, 32'h0);
      mp = 16'h00dd; sc = 16'h0191; mc = 16'h0191;
      repeat (5900) step();
      chk("hot_early", prot, 32'h04);
      repeat (200) step();
      chk("hot", prot, 32'h06);
      mp = '0; sc = 16'h00c9; mc = 16'h00c9;
      host.send(tsr_pkg::TSR_CLS, 8'h00);
      chk("hot20_clr", prot, 32'h0);
      repeat (11700) step();
      chk("hot20_early", prot, 32'h0);
      repeat (300) step();
      chk("hot20", prot, 32'h02);
      finish_test();
   end
endmodule : tb_top

//--- tsr_host_model.sv
// Host model that issues decoded messages to the bank and collects the answers.
// Assumes the bank takes a message on a rising edge and answers one cycle later.
`timescale 1ns/1ps
module tsr_host_model (
   input  wire logic               mclk_i,
   input  wire tsr_pkg::tsr_resp_t resp_i,
   output tsr_pkg::tsr_cmd_t       cmd_o
);
   logic [15:0] last_q;  // Data of the latest answer.
   logic        got_q;   // High when an answer stood in its cycle.
   initial cmd_o = '0;
   // Present one message for one rising edge, sample the answer it launched, then release.
   // The host issues only the command codes of tsr_pkg, each with one data byte.
   task automatic send(input tsr_pkg::tsr_cmd_e_t code, input logic [7:0] data);
      @(negedge mclk_i);
      cmd_o = {1'b1, code, data};
      @(negedge mclk_i);
      got_q = resp_i.valid;
      last_q = resp_i.data;
      cmd_o = {1'b0, ~code, ~data};
   endtask : send
endmodule : tsr_host_model

//--- tsr_pkg.sv
// Constants, command codes and carrier structs of the tester status and error register bank.
// Assumes one 200 MHz clock and that every user of these names writes tsr_pkg::name.
//
// Behaviour
// - Protection bit 5: current off by over ten percent.
// - Protection bit 4: remote enable input toggled.
// - Protection bit 3: voltage limiter engaged.
// - Protection bits 2,1,0: overload, overheat timer, temperature.
// - Higher variant timer: 10 min >40A, 30 min >20A.
// - Overload when power exceeds 150 or 220 VA.
// - Fail bit 2 upper, bit 1 lower.
// - Setting bit 3 resistance range, bit 2 power.
// - Setting bit 1: lower limit above upper.
// - Setting bit 0: test voltage above maximum.
// - Error bit 3 invalid message, bit 2 range.
// - Error bit 1 data, bit 0 syntax.
// - Clear-status zeroes all status registers, always accepted.
// - Event status query answers, then clears it.
// - Reset restores defaults, keeps interface settings.
// - Enable load refused in test or protection.
// - Buffer clear empties input, parser waits again.
// - Messages refused when their state flag forbids.
// - Identification answers model and firmware version always.
// - Event bit 4 on refused message.
// - Event bit 5 on syntax, data, range error.
// - Device status bit 1 shows bad setting.
package tsr_pkg;

   // Bit positions inside the protection register.
   localparam int PROT_CURRENT_DEVIATION_FLAG_BIT = 5;
   localparam int PROT_REN_BIT  = 4;
   localparam int PROT_VLIM_BIT = 3;
   localparam int PROT_OL_BIT   = 2;
   localparam int PROT_OHT_BIT  = 1;
   localparam int PROT_OT_BIT   = 0;
   // Bit positions inside the fail, event status, status byte and device status registers.
   localparam int FAIL_UP_BIT   = 2;
   localparam int FAIL_LO_BIT   = 1;
   localparam int ESR_EXEC_BIT  = 4;
   localparam int ESR_CMD_BIT   = 5;
   localparam int STB_ESB_BIT   = 5;
   localparam int STB_DSB_BIT   = 4;
   localparam int STB_MSS_BIT   = 6;
   localparam int DSR_BAD_BIT   = 1;
   // Masks of the implemented positions; all others stay zero.
   localparam logic [7:0] PROT_MASK = 8'h3f;
   localparam logic [7:0] FAIL_MASK = 8'h06;
   localparam logic [7:0] SET_MASK  = 8'h0f;
   localparam logic [7:0] ERR_MASK  = 8'h0f;
   localparam logic [7:0] ESR_MASK  = 8'h30;
   localparam logic [7:0] ZERO8     = 8'h00;
   // Analogue thresholds in the units of the measurement ports.
   localparam logic [15:0] AMP_40_DA     = 16'h0190;  // 40.0 A in 0.1 A units.
   localparam logic [15:0] AMP_20_DA     = 16'h00c8;  // 20.0 A in 0.1 A units.
   localparam logic [15:0] VA_LOW_RATED  = 16'h0096;  // 150 VA.
   localparam logic [15:0] VA_HIGH_RATED = 16'h00dc;  // 220 VA.
   localparam logic [15:0] VOLT_MAX_CV   = 16'h021c;  // 5.40 V in 0.01 V units.
   localparam logic [4:0]  DEV_TENTHS    = 5'h0a;     // Ten percent as a multiplier of the difference.
   // Timing of the overheat timer.
   localparam int unsigned CLK_MHZ      = 200;
   localparam int unsigned SEC_US       = 1000000;
   localparam int unsigned SEC_CYCLES   = CLK_MHZ * SEC_US;
   localparam logic [11:0] HOT40_SEC    = 12'h258;    // Ten minutes.
   localparam logic [11:0] HOT20_SEC    = 12'h708;    // Thirty minutes.

   // Command codes of the common and status messages.
   typedef enum logic [3:0] {
      TSR_CLS   = 4'h0, TSR_ESR_Q = 4'h1, TSR_IDN_Q = 4'h2, TSR_RST    = 4'h3,
      TSR_SRE   = 4'h4, TSR_SRE_Q = 4'h5, TSR_STB_Q = 4'h6, TSR_CLR    = 4'h7,
      TSR_ERR_Q = 4'h8, TSR_FAIL_Q = 4'h9, TSR_PROT_Q = 4'ha, TSR_SET_Q = 4'hb
   } tsr_cmd_e_t;

   // One decoded message from the parser.
   typedef struct packed {
      logic       valid;
      tsr_cmd_e_t code;
      logic [7:0] data;
   } tsr_cmd_t;

   // One answer to a query.
   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } tsr_resp_t;

endpackage : tsr_pkg

//--- tsr_status_bank.sv
// Status, condition and error register bank with common-message execution.
// Assumes a decoded message port from the parser and synchronous condition inputs.
`timescale 1ns/1ps
module tsr_status_bank #(
   parameter int unsigned SEC_CYCLES = tsr_pkg::SEC_CYCLES,  // Cycles per second.
   parameter logic [7:0]  MODEL_ID   = 8'h5a,                // Arbitrary model code.
   parameter logic [7:0]  ROM_VER    = 8'h01                 // Arbitrary firmware code.
) (
   input  wire logic              mclk_i,
   input  wire logic              arst_n_i,
   input  wire tsr_pkg::tsr_cmd_t cmd_i,
   output tsr_pkg::tsr_resp_t     resp_o,
   input  wire logic              testing_i,
   input  wire logic              protect_i,
   input  wire logic              high_rated_i,
   input  wire logic              output_on_i,
   input  wire logic [15:0]       meas_current_i,
   input  wire logic [15:0]       set_current_i,
   input  wire logic [15:0]       meas_power_i,
   input  wire logic              remote_enable_input_i,
   input  wire logic              voltage_limit_i,
   input  wire logic              overtemperature_i,
   input  wire logic              upper_fail_i,
   input  wire logic              lower_fail_i,
   input  wire logic              resistance_range_setting_i,
   input  wire logic              power_limit_setting_i,
   input  wire logic [15:0]       set_lower_i,
   input  wire logic [15:0]       set_upper_i,
   input  wire logic [15:0]       set_voltage_i,
   input  wire logic              invalid_msg_i,
   input  wire logic              range_err_i,
   input  wire logic              data_err_i,
   input  wire logic              syntax_err_i,
   input  wire logic [7:0]        dev_status_i,
   output logic [7:0]             protection_cause_o,
   output logic [7:0]             judgement_fail_o,
   output logic [7:0]             bad_setting_cause_o,
   output logic [7:0]             message_error_o,
   output logic [7:0]             event_status_o,
   output logic [7:0]             status_byte_o,
   output logic                   bad_setting_summary_o,
   output logic                   dev_status_clear_o,
   output logic                   factory_reset_o,
   output logic                   input_buffer_clear_o
);

   // Condition registers, event status and service request enable.
   logic [7:0]  prot_q, fail_q, set_q, err_q, esr_q, sre_q;
   logic [7:0]  prot_set, fail_set, set_set, err_set, esr_set;
   // Remote enable history for change detection.
   logic        ren_q;
   // Second divider and overheat counters.
   logic [31:0] tick_cnt_q;
   logic        sec_tick;
   logic [11:0] hot40_q, hot20_q;
   // Current deviation arithmetic.
   logic [15:0] cur_diff;
   logic [19:0] cur_diff_x10;
   // Message decode.
   logic        allowed;
   logic        exec;
   logic        refused;
   logic        do_cls;
   // Response register.
   tsr_pkg::tsr_resp_t resp_q;
   logic [15:0]         resp_d;
   logic [7:0]          stb;

   // Tells whether a message may run in the present state of the tester.
   function automatic logic msg_allowed(input tsr_pkg::tsr_cmd_e_t c, input logic tst,
                                        input logic prt);
      logic ok;
      ok = 1'b1;
      if (c == tsr_pkg::TSR_SRE) begin
         ok = !tst && !prt;
      end
      return ok;
   endfunction : msg_allowed

   // Decodes the message port against the availability flags.
   always_comb begin
      allowed = msg_allowed(cmd_i.code, testing_i, protect_i);
      exec    = cmd_i.valid && allowed;
      refused = cmd_i.valid && !allowed;
      do_cls  = exec && (cmd_i.code == tsr_pkg::TSR_CLS);
   end

   // Divides the clock down to a one-cycle pulse each second.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tick_cnt_q <= 32'h0000_0000;
      end else if (tick_cnt_q == 32'(SEC_CYCLES - 1)) begin
         tick_cnt_q <= 32'h0000_0000;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      end
   end
   assign sec_tick = (tick_cnt_q == 32'(SEC_CYCLES - 1));

   // Counts seconds spent above each current threshold on the higher variant.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hot40_q <= 12'h000;
         hot20_q <= 12'h000;
      end else begin
         if (!high_rated_i || !output_on_i || meas_current_i <= tsr_pkg::AMP_40_DA) begin
            hot40_q <= 12'h000;
         end else if (sec_tick && hot40_q != tsr_pkg::HOT40_SEC) begin
            hot40_q <= hot40_q + 12'h001;
         end
         if (!high_rated_i || !output_on_i || meas_current_i <= tsr_pkg::AMP_20_DA) begin
            hot20_q <= 12'h000;
         end else if (sec_tick && hot20_q != tsr_pkg::HOT20_SEC) begin
            hot20_q <= hot20_q + 12'h001;
         end
      end
   end

   // Remembers the remote enable level to spot every change.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ren_q <= 1'b0;
      end else begin
         ren_q <= remote_enable_input_i;
      end
   end

   // Builds the set sources of every condition register.
   always_comb begin
      cur_diff = (meas_current_i > set_current_i) ? meas_current_i - set_current_i
                                                  : set_current_i - meas_current_i;
      cur_diff_x10 = 20'(cur_diff) * 20'(tsr_pkg::DEV_TENTHS);
      prot_set = tsr_pkg::ZERO8;
      prot_set[tsr_pkg::PROT_CURRENT_DEVIATION_FLAG_BIT] = output_on_i
                                         && (cur_diff_x10 > 20'(set_current_i));
      prot_set[tsr_pkg::PROT_REN_BIT]  = remote_enable_input_i ^ ren_q;
      prot_set[tsr_pkg::PROT_VLIM_BIT] = voltage_limit_i;
      prot_set[tsr_pkg::PROT_OL_BIT]   = meas_power_i > (high_rated_i ? tsr_pkg::VA_HIGH_RATED
                                                         : tsr_pkg::VA_LOW_RATED);
      prot_set[tsr_pkg::PROT_OHT_BIT]  = (hot40_q == tsr_pkg::HOT40_SEC)
                                         || (hot20_q == tsr_pkg::HOT20_SEC);
      prot_set[tsr_pkg::PROT_OT_BIT]   = overtemperature_i;
      fail_set = tsr_pkg::ZERO8;
      fail_set[tsr_pkg::FAIL_UP_BIT] = upper_fail_i;
      fail_set[tsr_pkg::FAIL_LO_BIT] = lower_fail_i;
      set_set = {4'h0, resistance_range_setting_i, power_limit_setting_i,
                 set_lower_i > set_upper_i, set_voltage_i > tsr_pkg::VOLT_MAX_CV};
      err_set = {4'h0, invalid_msg_i, range_err_i, data_err_i, syntax_err_i};
      esr_set = tsr_pkg::ZERO8;
      esr_set[tsr_pkg::ESR_EXEC_BIT] = refused;
      esr_set[tsr_pkg::ESR_CMD_BIT]  = range_err_i || data_err_i || syntax_err_i;
   end

   // Holds the sticky condition registers; a set in a clearing cycle wins.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prot_q <= tsr_pkg::ZERO8;
         fail_q <= tsr_pkg::ZERO8;
         set_q  <= tsr_pkg::ZERO8;
         err_q  <= tsr_pkg::ZERO8;
      end else begin
         prot_q <= ((do_cls ? tsr_pkg::ZERO8 : prot_q) | prot_set) & tsr_pkg::PROT_MASK;
         fail_q <= ((do_cls ? tsr_pkg::ZERO8 : fail_q) | fail_set) & tsr_pkg::FAIL_MASK;
         set_q  <= ((do_cls ? tsr_pkg::ZERO8 : set_q) | set_set) & tsr_pkg::SET_MASK;
         err_q  <= ((do_cls ? tsr_pkg::ZERO8 : err_q) | err_set) & tsr_pkg::ERR_MASK;
      end
   end

   // Holds the event status register, cleared by clear-status or by its own query.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         esr_q <= tsr_pkg::ZERO8;
      end else if (do_cls || (exec && cmd_i.code == tsr_pkg::TSR_ESR_Q)) begin
         esr_q <= esr_set & tsr_pkg::ESR_MASK;
      end else begin
         esr_q <= (esr_q | esr_set) & tsr_pkg::ESR_MASK;
      end
   end

   // Loads the service request enable register; reset-to-defaults leaves it as it is.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sre_q <= tsr_pkg::ZERO8;
      end else if (exec && cmd_i.code == tsr_pkg::TSR_SRE) begin
         sre_q <= cmd_i.data;
      end
   end

   // Forms the status byte from the summaries and the enable register.
   always_comb begin
      stb = tsr_pkg::ZERO8;
      stb[tsr_pkg::STB_ESB_BIT] = |esr_q;
      stb[tsr_pkg::STB_DSB_BIT] = |dev_status_i || (|set_q);
      stb[tsr_pkg::STB_MSS_BIT] = |(stb & sre_q);
   end

   // Selects the answer to a query.
   always_comb begin
      resp_d = 16'h0000;
      unique case (cmd_i.code)
         tsr_pkg::TSR_ESR_Q:  resp_d = {8'h00, esr_q};
         tsr_pkg::TSR_IDN_Q:  resp_d = {MODEL_ID, ROM_VER};
         tsr_pkg::TSR_SRE_Q:  resp_d = {8'h00, sre_q};
         tsr_pkg::TSR_STB_Q:  resp_d = {8'h00, stb};
         tsr_pkg::TSR_ERR_Q:  resp_d = {8'h00, err_q};
         tsr_pkg::TSR_FAIL_Q: resp_d = {8'h00, fail_q};
         tsr_pkg::TSR_PROT_Q: resp_d = {8'h00, prot_q};
         tsr_pkg::TSR_SET_Q:  resp_d = {8'h00, set_q};
         default:             resp_d = 16'h0000;  // Non-query codes answer nothing.
      endcase
   end

   // Registers the answer one cycle after an accepted query.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         resp_q <= '0;
      end else begin
         resp_q.valid <= exec && (cmd_i.code inside {tsr_pkg::TSR_ESR_Q, tsr_pkg::TSR_IDN_Q,
                         tsr_pkg::TSR_SRE_Q, tsr_pkg::TSR_STB_Q, tsr_pkg::TSR_ERR_Q,
                         tsr_pkg::TSR_FAIL_Q, tsr_pkg::TSR_PROT_Q, tsr_pkg::TSR_SET_Q});
         resp_q.data  <= resp_d;
      end
   end

   // Registers the one-cycle action strobes sent to the rest of the tester.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dev_status_clear_o   <= 1'b0;
         factory_reset_o      <= 1'b0;
         input_buffer_clear_o <= 1'b0;
      end else begin
         dev_status_clear_o   <= do_cls;
         factory_reset_o      <= exec && cmd_i.code == tsr_pkg::TSR_RST;
         input_buffer_clear_o <= exec && cmd_i.code == tsr_pkg::TSR_CLR;
      end
   end

   // Drives the register views.
   assign resp_o                = resp_q;
   assign protection_cause_o    = prot_q;
   assign judgement_fail_o      = fail_q;
   assign bad_setting_cause_o   = set_q;
   assign message_error_o       = err_q;
   assign event_status_o        = esr_q;
   assign status_byte_o         = stb;
   assign bad_setting_summary_o = |set_q;

   // Checks that a remote enable change raises its cause bit next cycle.
   property p_ren_change;
      @(posedge mclk_i) disable iff (!arst_n_i)
      $changed(remote_enable_input_i) |=> prot_q[tsr_pkg::PROT_REN_BIT];
   endproperty
   a_ren_change: assert property (p_ren_change) else $error("remote change not flagged");

   // Checks that a refused enable load leaves the register and flags an execution error.
   sequence s_sre_refused;
      cmd_i.valid && cmd_i.code == tsr_pkg::TSR_SRE && (testing_i || protect_i);
   endsequence
   property p_sre_refused;
      @(posedge mclk_i) disable iff (!arst_n_i)
      s_sre_refused |=> $stable(sre_q) && esr_q[tsr_pkg::ESR_EXEC_BIT];
   endproperty
   a_sre_refused: assert property (p_sre_refused) else $error("refused load acted");

   // Checks that an allowed enable load stores the data.
   property p_sre_load;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (cmd_i.valid && cmd_i.code == tsr_pkg::TSR_SRE && !testing_i && !protect_i)
      |=> sre_q == $past(cmd_i.data);
   endproperty
   a_sre_load: assert property (p_sre_load) else $error("enable load lost");

   // Checks that clear-status empties the error register unless a new error arrives.
   property p_cls_clear;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (do_cls && !(invalid_msg_i || range_err_i || data_err_i || syntax_err_i))
      |=> err_q == tsr_pkg::ZERO8 && dev_status_clear_o;
   endproperty
   a_cls_clear: assert property (p_cls_clear) else $error("clear-status missed");

   // Checks that the event status query answers the old value and then clears.
   sequence s_esr_query;
      cmd_i.valid && cmd_i.code == tsr_pkg::TSR_ESR_Q && esr_set == tsr_pkg::ZERO8;
   endsequence
   property p_esr_query;
      @(posedge mclk_i) disable iff (!arst_n_i)
      s_esr_query |=> resp_o.valid && resp_o.data[7:0] == $past(esr_q)
                      && esr_q == tsr_pkg::ZERO8;
   endproperty
   a_esr_query: assert property (p_esr_query) else $error("event query wrong");

   // Checks that identification is answered even during a test in protection.
   property p_idn;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (cmd_i.valid && cmd_i.code == tsr_pkg::TSR_IDN_Q)
      |=> resp_o.valid && resp_o.data == {MODEL_ID, ROM_VER};
   endproperty
   a_idn: assert property (p_idn) else $error("identification missing");

   // Checks that a raised upper fail bit holds for the following cycles without a clear.
   property p_sticky;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (fail_q[tsr_pkg::FAIL_UP_BIT] && !do_cls) |=> fail_q[tsr_pkg::FAIL_UP_BIT];
   endproperty
   a_sticky: assert property (p_sticky) else $error("fail bit dropped");

   // Checks that unused protection and error positions never read as one.
   property p_unused_zero;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (prot_q & ~tsr_pkg::PROT_MASK) == tsr_pkg::ZERO8 && (err_q & ~tsr_pkg::ERR_MASK) == 8'h00;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

   // Checks that a lower limit above the upper one shows in the summary next cycle.
   property p_bad_summary;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (set_lower_i > set_upper_i) |=> bad_setting_summary_o;
   endproperty
   a_bad_summary: assert property (p_bad_summary) else $error("summary missing");

   // Checks that a buffer clear strobe drops again after one cycle when the message is not repeated.
   property p_buf_clear;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (cmd_i.valid && cmd_i.code == tsr_pkg::TSR_CLR) ##1 !(cmd_i.valid && cmd_i.code == tsr_pkg::TSR_CLR)
      |=> !input_buffer_clear_o;
   endproperty
   a_buf_clear: assert property (p_buf_clear) else $error("buffer clear stuck");

   // Checks that an accepted buffer clear raises its strobe in the next cycle.
   property p_buf_clear_rise;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (cmd_i.valid && cmd_i.code == tsr_pkg::TSR_CLR) |=> input_buffer_clear_o;
   endproperty
   a_buf_clear_rise: assert property (p_buf_clear_rise) else $error("buffer clear missing");

   // Checks that reset-to-defaults raises its strobe next cycle and keeps the enable register.
   property p_rst_strobe;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (cmd_i.valid && cmd_i.code == tsr_pkg::TSR_RST) |=> factory_reset_o && $stable(sre_q);
   endproperty
   a_rst_strobe: assert property (p_rst_strobe) else $error("reset strobe missing");

   // Checks that power above the higher rating raises the overload bit next cycle.
   property p_overload;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (high_rated_i && meas_power_i > tsr_pkg::VA_HIGH_RATED) |=> prot_q[tsr_pkg::PROT_OL_BIT];
   endproperty
   a_overload: assert property (p_overload) else $error("overload not flagged");

endmodule : tsr_status_bank
